// ===== rtl/deint_params.svh
`ifndef DEINT_PARAMS_SVH
`define DEINT_PARAMS_SVH
// Register byte addresses on the APB port.
`define REG_CTRL     8'h00
`define REG_STATUS   8'h04
`define REG_SIZE     8'h08
// Control register fields and reset value.
`define CTRL_METH_HI 1
`define CTRL_METH_LO 0
`define CTRL_DECAY   2
`define CTRL_C422    3
`define CTRL_PASS    4
`define CTRL_RESET   5'h01
// Interlace nibble of a control packet; bits 1:0 are sync bits.
`define NIB_ILACE    3
`define NIB_PAR      2
// Fields absorbed before the first output frame.
`define PRIME_FIELDS 2'h3
`define ONE_FIELD    2'h1
`endif

// ===== rtl/deint_pkg.sv
package deint_pkg;
  typedef enum logic [1:0] {ST_RECV, ST_DECIDE, ST_GEN} state_e;
  typedef enum logic [1:0] {M_DUP, M_INTERP, M_WEAVE, M_MOTION} method_e;
endpackage

// ===== rtl/video_field_deinterlacer.sv
// Functional notes
// RULE1: Frame per field or per field pair.
// RULE2: Pair mode keeps current field one parity.
// RULE3: Top parity field holds the first line.
// RULE4: Sync bits ignored; no segmented progressive handling.
// RULE5: Current parity is a build-time parameter.
// RULE6: Duplication emits each current line twice.
// RULE7: Line methods drop the unused parity.
// RULE8: Interpolation averages lines above and below.
// RULE9: Edge missing line copies its only neighbour.
// RULE10: Weave fills from the preceding field.
// RULE11: Weave needs external double or triple buffering.
// RULE12: Motion uses current and three preceding fields.
// RULE13: Raw motion is min absolute difference.
// RULE14: Motion scaled to pixel sample range.
// RULE15: Decay keeps higher motion, averages lower.
// RULE16: Diagonal edge picks diagonal interpolation pixels.
// RULE17: 4:2:2 mode avoids diagonal chroma interpolation.
// RULE18: Blend weighted interpolation with still pixel.
// RULE19: First three fields produce no output.
// RULE20: Unequal field sizes restart priming.
// RULE21: Progressive frames dropped unless pass-through.
// RULE22: Source avoids taller top parity fields.
// RULE23: Missing control packet infers type from previous.
// RULE24: Repeated parity field discarded in weave/motion.
// RULE25: Motion weight spans still to full motion.
// RULE26: Ready/valid streams; input stalls while busy.
`timescale 1ns/1ps
`include "deint_params.svh"
module video_field_deinterlacer
  import deint_pkg::*;
#(
  parameter int W           = 8,
  parameter int MAX_W       = 16,
  parameter int MAX_H       = 16,
  parameter bit PER_FIELD   = 1'b0,
  parameter bit CUR_PARITY  = 1'b0,
  parameter bit INIT_PARITY = 1'b0,
  parameter int EXT_BUF     = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         ctrl_valid,
  input  wire logic [3:0]   ctrl_nibble,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_eol,
  input  wire logic         in_eof,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data,
  output logic              out_sof,
  output logic              out_eol,
  output logic              out_eof
);
  localparam int XW = $clog2(MAX_W);
  localparam int YW = $clog2(MAX_H);

  // Field stores are addressed by concatenation, so sizes are powers of two.
  if (W < 2 || MAX_W < 4 || MAX_H < 4 || (1 << XW) != MAX_W ||
      (1 << YW) != MAX_H || EXT_BUF < 0 || EXT_BUF > 2) begin : g_bad
    $error("video_field_deinterlacer: unsupported parameters");
  end

  typedef struct packed {
    state_e        state;
    logic          in_ready;
    logic [XW-1:0] col;
    logic [YW-1:0] line;
    logic [XW-1:0] rx_w;
    logic [1:0]    wr_buf;
    logic [1:0]    cur_buf;
    logic          got_ctrl;
    logic          ctrl_ilace;
    logic          ctrl_par;
    logic          cur_prog;
    logic          cur_par;
    logic          last_prog;
    logic          last_par;
    logic          have_prev;
    logic [XW-1:0] last_w;
    logic [YW-1:0] last_h;
    logic [1:0]    seen;
    method_e       method;
    logic          decay;
    logic          c422;
    logic          pass;
    logic [YW-1:0] orow;
    logic [XW-1:0] ocol;
    logic          out_valid;
    logic [W-1:0]  out_data;
    logic          out_sof;
    logic          out_eol;
    logic          out_eof;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic [15:0]   frames;
    logic [15:0]   drops;
  } st_s;

  st_s r;
  st_s next_r;

  // Four field stores: current plus three preceding fields.
  logic [W-1:0] fmem [0:4*MAX_W*MAX_H-1];
  logic [W-1:0] mot  [0:MAX_W*MAX_H-1];

  logic            accept;
  logic            emit;
  logic            missing;
  logic            mot_we;
  logic [W-1:0]    mot_wdata;
  logic [W-1:0]    pix;
  logic [YW-1:0]   oh_last;
  logic [YW-1:0]   hh;
  logic [YW-1:0]   la;
  logic [YW-1:0]   lb;
  logic [1:0]      b_p1;
  logic [1:0]      b_p2;
  logic [1:0]      b_p3;
  logic [XW-1:0]   cx     [3];
  logic [W-1:0]    ca     [3];
  logic [W-1:0]    cb     [3];
  logic [W-1:0]    p2a    [3];
  logic [W-1:0]    p2b    [3];
  logic [W-1:0]    p1m    [3];
  logic [W-1:0]    p3m    [3];
  logic [W-1:0]    mraw;
  logic [W-1:0]    mnorm;
  logic [W-1:0]    mstored;
  logic [W-1:0]    muse;
  logic [W-1:0]    upper;
  logic [W-1:0]    lower;
  logic [W-1:0]    still;
  logic [W-1:0]    dv;
  logic [W-1:0]    d1;
  logic [W-1:0]    d2;
  logic [W:0]      wgt;
  logic [2*W+1:0]  mix;

  function automatic logic [W-1:0] absd(input logic [W-1:0] a,
                                        input logic [W-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [W-1:0] avg2(input logic [W-1:0] a,
                                        input logic [W-1:0] b);
    logic [W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[W:1];
  endfunction

  function automatic logic [W-1:0] rd(input logic [1:0]    b,
                                      input logic [YW-1:0] l,
                                      input logic [XW-1:0] c);
    return fmem[{b, l, c}];
  endfunction

  assign accept  = in_valid && r.in_ready;
  assign emit    = (r.state == ST_GEN) && (!r.out_valid || out_ready);
  assign oh_last = r.cur_prog ? r.last_h : {r.last_h[YW-2:0], 1'b1};

  // Pixel path for output row orow and column ocol. Top parity holds the
  // even rows, so a row is present when its low bit equals the parity.
  always_comb begin
    hh      = r.orow >> 1;
    missing = !r.cur_prog && (r.orow[0] != r.cur_par); // RULE3
    b_p1    = r.cur_buf - 2'h1;
    b_p2    = r.cur_buf - 2'h2;
    b_p3    = r.cur_buf - 2'h3; // RULE12
    // A line with no neighbour on one side reuses the other one.
    la = r.cur_par ? hh - 1'b1 : hh;
    lb = r.cur_par ? hh : hh + 1'b1;
    if (r.cur_par && hh == '0) begin
      la = lb; // RULE9
    end
    if (!r.cur_par && hh == r.last_h) begin
      lb = la; // RULE9
    end
    cx[0] = (r.ocol == '0) ? r.ocol : r.ocol - 1'b1;
    cx[1] = r.ocol;
    cx[2] = (r.ocol == r.last_w) ? r.ocol : r.ocol + 1'b1;
    for (int j = 0; j < 3; j++) begin
      ca[j]  = rd(r.cur_buf, la, cx[j]);
      cb[j]  = rd(r.cur_buf, lb, cx[j]);
      p2a[j] = rd(b_p2, la, cx[j]);
      p2b[j] = rd(b_p2, lb, cx[j]);
      p1m[j] = rd(b_p1, hh, cx[j]);
      p3m[j] = rd(b_p3, hh, cx[j]);
    end
    // Two 3x3 groups: current/previous versus the pair before them.
    mraw = '1;
    for (int j = 0; j < 3; j++) begin
      if (absd(ca[j], p2a[j]) < mraw) begin
        mraw = absd(ca[j], p2a[j]); // RULE13
      end
      if (absd(p1m[j], p3m[j]) < mraw) begin
        mraw = absd(p1m[j], p3m[j]); // RULE13
      end
      if (absd(cb[j], p2b[j]) < mraw) begin
        mraw = absd(cb[j], p2b[j]); // RULE13
      end
    end
    // The difference already spans the sample range; no shift needed.
    mnorm   = mraw; // RULE14
    mstored = mot[{hh, r.ocol}];
    muse    = mnorm;
    mot_wdata = mnorm;
    if (r.decay && mnorm < mstored) begin
      muse      = mstored; // RULE15
      mot_wdata = avg2(mnorm, mstored); // RULE15
    end
    mot_we = emit && missing && r.decay && r.method == M_MOTION;
    // Edge search picks the pair with the smallest difference.
    dv    = absd(ca[1], cb[1]);
    d1    = absd(ca[0], cb[2]);
    d2    = absd(ca[2], cb[0]);
    upper = ca[1];
    lower = cb[1];
    // Chroma sits on odd columns and is never taken along a diagonal.
    if (!(r.c422 && r.ocol[0])) begin // RULE17
      if (d1 < dv && d1 <= d2) begin
        upper = ca[0]; // RULE16
        lower = cb[2];
      end else if (d2 < dv) begin
        upper = ca[2]; // RULE16
        lower = cb[0];
      end
    end
    still = p1m[1];
    // Weight 0 for still pixels up to 2**W at full motion.
    wgt = {1'b0, muse} + {{W{1'b0}}, muse[W-1]}; // RULE25
    mix = {{(W+1){1'b0}}, wgt} * {{(W+1){1'b0}}, avg2(upper, lower)}
        + {{(W+1){1'b0}}, (W+1)'(1 << W) - wgt}
        * {{(W+1){1'b0}}, 1'b0, still}; // RULE18
    pix = rd(r.cur_buf, hh, r.ocol);
    if (r.cur_prog) begin
      pix = rd(r.cur_buf, r.orow, r.ocol); // RULE21
    end else if (missing) begin
      unique case (r.method)
        M_DUP:    pix = rd(r.cur_buf, hh, r.ocol); // RULE6
        M_INTERP: pix = avg2(ca[1], cb[1]); // RULE8
        M_WEAVE:  pix = still; // RULE10
        M_MOTION: pix = mix[2*W-1:W]; // RULE18
      endcase
    end
  end

  // Next-state logic for reception, field decisions, output and APB.
  always_comb begin
    logic       np;
    logic       npar;
    logic       resize;
    logic       same_par;
    logic       produce;
    logic       keep;
    logic [1:0] seen_inc;
    next_r = r;
    np       = r.last_prog;
    npar     = !r.last_par;
    resize   = 1'b0;
    same_par = 1'b0;
    produce  = 1'b0;
    keep     = 1'b0;
    seen_inc = (r.seen == `PRIME_FIELDS) ? r.seen : r.seen + 1'b1;
    unique case (r.state)
      ST_RECV: begin
        // Control packet is taken only before the first beat of a field.
        if (ctrl_valid && r.line == '0 && r.col == '0) begin
          next_r.got_ctrl   = 1'b1;
          next_r.ctrl_ilace = ctrl_nibble[`NIB_ILACE]; // RULE4
          next_r.ctrl_par   = ctrl_nibble[`NIB_PAR];
        end
        if (accept) begin
          if (in_eol) begin
            next_r.rx_w = r.col;
            next_r.col  = '0;
            if (r.line != '1) begin
              next_r.line = r.line + 1'b1;
            end
          end else if (r.col != '1) begin
            next_r.col = r.col + 1'b1;
          end
          if (in_eof) begin
            next_r.line  = r.line;
            next_r.state = ST_DECIDE;
          end
        end
      end
      ST_DECIDE: begin
        if (r.got_ctrl) begin
          np   = !r.ctrl_ilace;
          npar = r.ctrl_par;
        end else if (r.last_prog) begin
          npar = r.last_par; // RULE23
        end
        resize = !r.have_prev || r.rx_w != r.last_w ||
                 r.line != r.last_h; // RULE20 RULE22
        same_par = !r.last_prog && npar == r.last_par && r.have_prev;
        next_r.got_ctrl = 1'b0;
        next_r.line     = '0;
        next_r.col      = '0;
        next_r.state    = ST_RECV;
        if (np) begin
          next_r.last_prog = 1'b1;
          if (r.pass) begin
            keep    = 1'b1; // RULE21
            produce = 1'b1;
          end
        end else if (r.method >= M_WEAVE && same_par) begin
          keep = 1'b0; // RULE24
        end else begin
          next_r.last_prog = 1'b0;
          next_r.last_par  = npar;
          next_r.seen      = resize ? `ONE_FIELD : seen_inc; // RULE19
          keep = r.method >= M_WEAVE || PER_FIELD ||
                 npar == CUR_PARITY; // RULE7
          produce = !resize && r.seen == `PRIME_FIELDS && // RULE19
                    (PER_FIELD || npar == CUR_PARITY); // RULE1 RULE2 RULE5
        end
        if (keep) begin
          next_r.cur_buf   = r.wr_buf;
          next_r.wr_buf    = r.wr_buf + 1'b1;
          next_r.cur_prog  = np;
          next_r.cur_par   = npar;
          next_r.have_prev = 1'b1;
          next_r.last_w    = r.rx_w;
          next_r.last_h    = r.line;
        end
        if (produce) begin
          next_r.state = ST_GEN;
          next_r.orow  = '0;
          next_r.ocol  = '0;
        end else begin
          next_r.drops = r.drops + 1'b1;
        end
      end
      ST_GEN: begin
        if (emit) begin
          next_r.ocol = r.ocol + 1'b1;
          if (r.ocol == r.last_w) begin
            next_r.ocol = '0;
            next_r.orow = r.orow + 1'b1;
            if (r.orow == oh_last) begin
              next_r.state  = ST_RECV;
              next_r.frames = r.frames + 1'b1;
            end
          end
        end
      end
      default: next_r.state = ST_RECV;
    endcase
    // Output register holds its beat until the sink takes it.
    if (emit) begin
      next_r.out_valid = 1'b1;
      next_r.out_data  = pix;
      next_r.out_sof   = r.orow == '0 && r.ocol == '0;
      next_r.out_eol   = r.ocol == r.last_w;
      next_r.out_eof   = r.ocol == r.last_w && r.orow == oh_last;
    end else if (out_ready) begin
      next_r.out_valid = 1'b0; // RULE26
    end
    next_r.in_ready = next_r.state == ST_RECV; // RULE26
    // Register slave answers in the first access cycle.
    next_r.pready  = psel && !penable;
    next_r.pslverr = 1'b0;
    next_r.prdata  = '0;
    if (psel && !penable) begin
      unique case (paddr)
        `REG_CTRL:   next_r.prdata = 32'({r.pass, r.c422, r.decay,
                                          r.method});
        `REG_STATUS: next_r.prdata = {r.frames, r.drops[7:0], 3'h0,
                                      r.state == ST_GEN, r.cur_prog,
                                      r.cur_par, r.seen};
        `REG_SIZE:   next_r.prdata = 32'({r.last_h, r.last_w});
        default:     next_r.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && r.pready && pwrite && paddr == `REG_CTRL) begin
      next_r.decay = pwdata[`CTRL_DECAY];
      next_r.c422  = pwdata[`CTRL_C422];
      next_r.pass  = pwdata[`CTRL_PASS];
      // Field-pair methods need the external buffers; keep the old one.
      if (EXT_BUF != 0 || pwdata[`CTRL_METH_HI] == 1'b0) begin // RULE11
        next_r.method = method_e'(pwdata[`CTRL_METH_HI:`CTRL_METH_LO]);
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      r           <= '0;
      r.state     <= ST_RECV;
      r.method    <= method_e'(2'(`CTRL_RESET));
      r.last_par  <= !INIT_PARITY;
    end else begin
      r <= next_r;
    end
  end

  // Field and motion stores carry no reset. A stored motion value is
  // unknown until its position has been written once after power-up.
  always_ff @(posedge clk_sys) begin
    if (accept) begin
      fmem[{r.wr_buf, r.line, r.col}] <= in_data;
    end
    if (mot_we) begin
      mot[{hh, r.ocol}] <= mot_wdata; // RULE15
    end
  end

  assign in_ready  = r.in_ready;
  assign out_valid = r.out_valid;
  assign out_data  = r.out_data;
  assign out_sof   = r.out_sof;
  assign out_eol   = r.out_eol;
  assign out_eof   = r.out_eof;
  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;

  // Checks on the decisions above.
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_input_stall: assert property ( // RULE26
    (r.state != ST_RECV) |-> !in_ready)
    else $error("input ready while busy");
  a_output_hold: assert property ( // RULE26
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("output beat changed before taken");
  a_prime_count: assert property ( // RULE19
    (r.state == ST_DECIDE ##1 r.state == ST_GEN && !r.cur_prog)
    |-> r.seen == `PRIME_FIELDS)
    else $error("frame produced while priming");
  a_pair_parity: assert property ( // RULE2
    (r.state == ST_GEN && !r.cur_prog && !PER_FIELD)
    |-> r.cur_par == CUR_PARITY)
    else $error("pair mode current field has wrong parity");
  a_repeat_drop: assert property ( // RULE24
    (r.state == ST_DECIDE && r.got_ctrl && r.ctrl_ilace &&
     r.ctrl_par == r.last_par && !r.last_prog && r.have_prev &&
     r.method >= M_WEAVE) |=> (r.state == ST_RECV &&
     $stable(r.wr_buf) && $stable(r.seen)))
    else $error("repeated parity field was not discarded");
  a_prog_drop: assert property ( // RULE21
    (r.state == ST_DECIDE && r.got_ctrl && !r.ctrl_ilace && !r.pass)
    |=> (r.state == ST_RECV && $changed(r.drops)))
    else $error("progressive frame not dropped");
  a_weave_guard: assert property ( // RULE11
    (EXT_BUF == 0) |-> r.method < M_WEAVE)
    else $error("field-pair method without external buffers");
  a_decay_mean: assert property ( // RULE15
    (mot_we && mnorm < mstored) |-> (mot_wdata >= mnorm &&
     mot_wdata <= mstored && muse == mstored))
    else $error("decay did not keep stored motion");
  a_apb_answer: assert property (
    (psel && !penable) |=> (pready ##1 !pready))
    else $error("register answer not one cycle");
  c_motion_frame: cover property (
    r.method == M_MOTION && out_valid && out_eof && out_ready);
  c_prog_pass: cover property (
    r.state == ST_GEN && r.cur_prog && out_sof);
  c_field_drop: cover property (
    r.state == ST_DECIDE ##1 (r.state == ST_RECV && $changed(r.drops)));
endmodule

// ===== bench/video_partner.sv
`timescale 1ns/1ps
// Upstream source and downstream sink of the video streams.
module video_partner (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  output logic            ctrl_valid,
  output logic      [3:0] ctrl_nibble,
  output logic            in_valid,
  input  wire logic       in_ready,
  output logic      [7:0] in_data,
  output logic            in_eol,
  output logic            in_eof,
  input  wire logic       out_valid,
  output logic            out_ready,
  input  wire logic [7:0] out_data,
  input  wire logic       out_sof,
  input  wire logic       out_eol,
  input  wire logic       out_eof
);
  logic [10:0] q[$];
  logic [1:0]  cyc;

  // Source lines start idle so nothing is offered before reset ends.
  initial begin
    ctrl_valid  = 1'b0;
    ctrl_nibble = 4'h0;
    in_valid    = 1'b0;
    in_data     = 8'h00;
    in_eol      = 1'b0;
    in_eof      = 1'b0;
  end

  // Sends one field four pixels wide; a control packet goes only while
  // the device is receiving, since it ignores one at any other time.
  task automatic send_field(input logic       use_ctrl,
                            input logic [3:0] nib,
                            input logic [7:0] base,
                            input int         nl);
    int l;
    int k;
    do @(posedge clk_sys); while (in_ready !== 1'b1);
    if (use_ctrl) begin
      ctrl_valid  <= 1'b1;
      ctrl_nibble <= nib;
      @(posedge clk_sys);
      ctrl_valid  <= 1'b0;
      ctrl_nibble <= ~nib;
    end
    for (l = 0; l < nl; l++) begin
      for (k = 0; k < 4; k++) begin
        in_valid <= 1'b1;
        in_data  <= 8'(base + l * 4 + k);
        in_eol   <= (k == 3);
        in_eof   <= (k == 3) && (l == nl - 1);
        do @(posedge clk_sys); while (in_ready !== 1'b1);
      end
    end
    in_valid <= 1'b0;
    in_data  <= ~in_data;
    in_eol   <= 1'b0;
    in_eof   <= 1'b0;
  endtask

  // The sink stalls one cycle in four, so back-pressure is always seen.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_ready <= 1'b0;
      cyc       <= 2'h0;
    end else begin
      cyc       <= cyc + 2'h1;
      out_ready <= (cyc != 2'h3);
      if (out_valid && out_ready) begin
        q.push_back({out_sof, out_eol, out_eof, out_data});
      end
    end
  end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`include "deint_params.svh"
module tb_top;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic        err;
  } apb_row_s;

  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, in_data, out_data;
  logic [31:0] pwdata, prdata, rd;
  logic        ctrl_valid, in_valid, in_ready, in_eol, in_eof, err;
  logic        out_valid, out_ready, out_sof, out_eol, out_eof;
  logic [3:0]  ctrl_nibble;
  int          n_fail, total_checks, cycles;
  apb_row_s    rows [7];
  int          off [5][4];

  video_field_deinterlacer #(.PER_FIELD(1'b0), .CUR_PARITY(1'b0),
    .INIT_PARITY(1'b0), .EXT_BUF(1)) DUT (.clk_sys(clk_sys),
    .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ctrl_valid(ctrl_valid),
    .ctrl_nibble(ctrl_nibble), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_eol(in_eol),
    .in_eof(in_eof), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_sof(out_sof), .out_eol(out_eol),
    .out_eof(out_eof));

  video_partner part (.clk_sys(clk_sys), .reset_n(reset_n),
    .ctrl_valid(ctrl_valid), .ctrl_nibble(ctrl_nibble),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .in_eol(in_eol), .in_eof(in_eof), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_sof(out_sof),
    .out_eol(out_eol), .out_eof(out_eof));

  // Free-running 20 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang ends as a mismatch; a full run needs far fewer cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      give_verdict();
    end
  end

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q       = prdata;
    e       = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    part.q.delete();
  endtask

  // Checks one 4x4 output frame against the line offsets of method m.
  task automatic chk_frame(input int m);
    logic [7:0] base;
    int         i;
    i = 0;
    while (part.q.size() < 16 && i < 6000) begin
      @(posedge clk_sys);
      i++;
    end
    chk("pixel count", 32'(part.q.size() >= 16), 32'h1);
    if (part.q.size() < 16) return;
    base = {part.q[0][7:4], 4'h0};
    if (m < 4) chk("parity", {31'h0, base[4]}, 32'h0);
    chk("sof", {31'h0, part.q[0][10]}, 32'h1);
    chk("eof", {31'h0, part.q[15][8]}, 32'h1);
    for (i = 0; i < 16; i++) begin
      chk("eol", {31'h0, part.q[i][9]}, 32'(i % 4 == 3));
      chk("pixel", {24'h0, part.q[i][7:0]},
          {24'h0, 8'(base + off[m][i / 4] + i % 4)});
    end
    part.q.delete();
  endtask

  // Streams eight fields in method m, nine in method 2, and checks the first frame.
  task automatic run(input int m, input logic [31:0] cw,
                     input logic all_ctrl, input logic [1:0] sy);
    int         n;
    logic [7:0] b;
    do_reset();
    apb(1'b1, `REG_CTRL, cw, rd, err);
    if (m == 2) begin
      part.send_field(1'b1, {2'b10, sy}, 8'hE0, 2);
      part.send_field(1'b1, {2'b10, sy}, 8'h00, 2);
      apb(1'b0, `REG_STATUS, 32'h0, rd, err);
      chk("dropped", {24'h0, rd[15:8]}, 32'h2);
      chk("seen", {30'h0, rd[1:0]}, 32'h1);
    end
    for (n = (m == 2); n < 8; n++) begin
      b = (m == 3) ? (n[0] ? 8'h40 : 8'h00) : 8'(n * 16);
      part.send_field(all_ctrl || n == 0, {1'b1, n[0], sy}, b, 2);
      if (n == 3) chk("early output", 32'(part.q.size()), 0);
    end
    chk_frame(m);
    $display("test of method %0d done", m);
  endtask

  // Register rows first, then one run per method and pass-through.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset_n = 1'b0;
    n_fail = 0;
    total_checks = 0;
    cycles = 0;
    off = '{'{0, 0, 4, 4}, '{0, 2, 4, 4}, '{0, -16, 4, -12},
            '{0, 64, 4, 68}, '{0, 4, 8, 12}};
    rows = '{'{1'b0, `REG_CTRL, 32'h0, {27'h0, `CTRL_RESET}, 1'b0},
             '{1'b1, `REG_CTRL, 32'h1E, 32'h0, 1'b0},
             '{1'b0, `REG_CTRL, 32'h0, 32'h1E, 1'b0},
             '{1'b1, `REG_CTRL, 32'h0F, 32'h0, 1'b0},
             '{1'b0, `REG_CTRL, 32'h0, 32'h0F, 1'b0},
             '{1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0, 1'b1},
             '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1}};
    do_reset();
    chk("out_valid", {31'h0, out_valid}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, err);
      if (!rows[i].wr) chk("prdata", rd, rows[i].exp);
      chk("pslverr", {31'h0, err}, {31'h0, rows[i].err});
    end
    $display("register test done");
    run(0, 32'h00, 1'b1, 2'b11);
    run(1, 32'h01, 1'b0, 2'b00);
    run(2, 32'h02, 1'b1, 2'b01);
    run(3, 32'h0F, 1'b1, 2'b10);
    do_reset();
    apb(1'b1, `REG_CTRL, 32'h01, rd, err);
    part.send_field(1'b1, 4'h0, 8'h00, 4);
    part.send_field(1'b0, 4'h0, 8'h10, 4);
    apb(1'b0, `REG_STATUS, 32'h0, rd, err);
    chk("dropped", {24'h0, rd[15:8]}, 32'h2);
    chk("progressive", {31'h0, rd[3]}, 32'h0);
    chk("no output", 32'(part.q.size()), 0);
    apb(1'b1, `REG_CTRL, 32'h11, rd, err);
    for (int n = 2; n < 6; n++) part.send_field(1'b0, 4'h0, 8'(n * 16), 4);
    chk_frame(4);
    apb(1'b0, `REG_STATUS, 32'h0, rd, err);
    chk("progressive", {31'h0, rd[3]}, 32'h1);
    $display("pass-through test done");
    give_verdict();
  end
endmodule
